/* File: bench/scs_peer.sv */
// Behavioural target on the far side of the serial link.
// Assumes clock polarity 0 and clock phase 1 at the controller.
module scs_peer (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic [7:0] load,
	output logic [7:0] got,
	output logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial begin
		miso = 1'b0;
		got = 8'h00;
		sh = 8'h00;
	end
	always @(negedge sel_n) begin
		sh = load;
	end
	// The first leading edge starts the byte, most significant bit first.
	always @(posedge sclk) begin
		if (!sel_n) begin
			miso = sh[7];
			sh = {sh[6:0], 1'b0};
		end
	end
	always @(negedge sclk) begin
		if (!sel_n) begin
			got = {got[6:0], mosi};
		end
	end
	// A released line flips so that a stale bit is never read as valid.
	always @(posedge sel_n) begin
		miso = ~miso;
	end
endmodule : scs_peer

/* File: bench/scs_port_monitor.sv */
// Checker for the register port and pins of the serial port.
// Assumes it is bound to every instance of scs_port on ref_clk.
module scs_port_monitor
	import scs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe_n,
	input wire logic miso_oe_n,
	input wire logic select_n,
	input wire logic pullup_en,
	input wire logic irq_tx_empty,
	input wire logic irq_error
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!rd_en |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray data");
	property p_unmapped;
		rd_en && (addr < ADDR_CONTROL || addr > ADDR_DATA) |=> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
	property p_rsvd;
		rd_en && addr == ADDR_CONTROL |=> !rd_data[6];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_sel_hi;
		select_n [*4] |-> miso_oe_n;
	endproperty
	a_sel_hi: assert property (p_sel_hi) else $error("data out driven");
	property p_wom;
		!pullup_en && !serial_clock_pin_oe_n |-> !serial_clock_pin_out;
	endproperty
	a_wom: assert property (p_wom) else $error("clock driven high");
	property p_pull;
		wr_en && addr == ADDR_CONTROL |=>
			##2 pullup_en == !$past(wr_data[CTL_WOM], 3);
	endproperty
	a_pull: assert property (p_pull) else $error("pullup wrong");
	property p_txie;
		wr_en && addr == ADDR_CONTROL && !wr_data[CTL_TX_IE] |=> ##2 !irq_tx_empty;
	endproperty
	a_txie: assert property (p_txie) else $error("tx request");
	property p_error_irq_enable;
		wr_en && addr == ADDR_STATUS && !wr_data[ST_ERR_IE] |=> ##2 !irq_error;
	endproperty
	a_error_irq_enable: assert property (p_error_irq_enable) else $error("error request");
	property p_rate;
		$changed(serial_clock_pin_out) |=> $stable(serial_clock_pin_out);
	endproperty
	a_rate: assert property (p_rate) else $error("clock too fast");
	property p_ctl;
		wr_en && addr == ADDR_CONTROL && wr_data[CTL_MASTER] |=> ##2 miso_oe_n;
	endproperty
	a_ctl: assert property (p_ctl) else $error("data out driven");
endmodule : scs_port_monitor

bind scs_port scs_port_monitor i_mon (.ref_clk(ref_clk), .rst_n(rst_n),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe_n(serial_clock_pin_oe_n), .miso_oe_n(miso_oe_n),
	.select_n(select_n), .pullup_en(pullup_en),
	.irq_tx_empty(irq_tx_empty), .irq_error(irq_error));

/* File: bench/spi_control_status_data_regs_test.sv */
// Self-checking bench for the serial port in controller mode.
// Assumes the peer target model and the bound checker.
module spi_control_status_data_regs_test
	import scs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_n, wr_en, rd_en, sel_n;
	logic [7:0] addr, wr_data, rd_data, pv, tv, p1, got;
	logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_w;
	logic pullup_en, irq_rx_full, irq_tx_empty, irq_error;
	int err_total, total_checks;
	wire logic sck_w = sck_oe_n ? 1'b1 : sck_o;
	wire logic mosi_w = mosi_oe_n ? 1'b1 : mosi_o;
	scs_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_n(sck_oe_n), .mosi_in(mosi_w),
		.mosi_out(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
		.miso_out(), .miso_oe_n(), .select_n(sel_n), .pullup_en(pullup_en),
		.irq_rx_full(irq_rx_full), .irq_tx_empty(irq_tx_empty),
		.irq_error(irq_error));
	scs_peer i_peer (.sclk(sck_w), .mosi(mosi_w), .sel_n(sel_n),
		.load(pv), .got(got), .miso(miso_w));
	function automatic logic [7:0] div_of(input int r);
		return 8'h02 << (2 * r);
	endfunction : div_of
	task automatic print_verdict;
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, e);
	endtask : rc
	task automatic xfer(input int r, input logic [7:0] t);
		int c;
		logic old;
		@(posedge ref_clk);
		pv <= 8'($urandom);
		@(posedge ref_clk);
		sel_n <= 1'b0;
		wr(ADDR_DATA, t);
		@(sck_o);
		old = sck_o;
		c = 0;
		while (sck_o === old && c < 300) begin
			@(posedge ref_clk);
			#1 c++;
		end
		chk(c[7:0], div_of(r));
		repeat (16 * div_of(r)) @(posedge ref_clk);
		sel_n <= 1'b1;
		chk(got, t);
	endtask : xfer
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#100us;
		err_total++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		sel_n = 1'b1;
		pv = 8'h00;
		void'($urandom(32'h0088));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		rc(ADDR_CONTROL, 8'h28);
		rc(ADDR_STATUS, 8'h08);
		rc(8'h13, 8'h00);
		wr(ADDR_CONTROL, 8'hab);
		repeat (3) @(posedge ref_clk);
		chk({7'h00, irq_tx_empty}, 8'h01);
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_STATUS, 8'(r));
			tv = 8'($urandom);
			xfer(r, tv);
			rc(ADDR_STATUS, 8'h88 | 8'(r));
			chk({7'h00, irq_rx_full}, 8'h01);
			rc(ADDR_DATA, pv);
			rc(ADDR_STATUS, 8'h08 | 8'(r));
		end
		wr(ADDR_STATUS, 8'h00);
		tv = 8'($urandom);
		xfer(0, tv);
		p1 = pv;
		xfer(0, ~tv);
		rc(ADDR_STATUS, 8'ha8);
		rc(ADDR_DATA, p1);
		rc(ADDR_STATUS, 8'h08);
		wr(ADDR_STATUS, 8'h44);
		sel_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rc(ADDR_STATUS, 8'h5c);
		chk({7'h00, irq_error}, 8'h01);
		sel_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wr(ADDR_STATUS, 8'h40);
		rc(ADDR_STATUS, 8'h48);
		chk({7'h00, irq_error}, 8'h00);
		wr(ADDR_CONTROL, 8'h26);
		repeat (3) @(posedge ref_clk);
		chk({7'h00, pullup_en}, 8'h00);
		chk({7'h00, irq_tx_empty}, 8'h00);
		print_verdict();
	end
endmodule : spi_control_status_data_regs_test

/* File: src/scs_pkg.sv */
// Constants, register layout and state record of the byte-wide serial port.
// Assumes a single 200 MHz clock and an 8-bit register port on that clock.
package scs_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h11;
	localparam logic [7:0] ADDR_DATA = 8'h12;

	// Bit positions of serial_port_control.
	localparam int CTL_RX_IE = 7;
	localparam int CTL_MASTER = 5;
	localparam int CTL_CLOCK_POLARITY_BIT = 4;
	localparam int CTL_CLOCK_PHASE_BIT = 3;
	localparam int CTL_WOM = 2;
	localparam int CTL_EN = 1;
	localparam int CTL_TX_IE = 0;
	localparam logic [7:0] CONTROL_WR_MASK = 8'hbf;
	localparam logic [7:0] CONTROL_RESET = 8'h28;

	// Bit positions of serial_port_status_control.
	localparam int ST_RX_FULL = 7;
	localparam int ST_ERR_IE = 6;
	localparam int ST_OVERRUN = 5;
	localparam int ST_MODE_FAULT = 4;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_MODE_FAULT_FLAG_EN = 2;
	localparam int ST_RATE_HI = 1;
	localparam int ST_RATE_LO = 0;

	// Controller rate divisors; the bit clock toggles every divisor cycles.
	localparam logic [7:0] RATE_DIV_0 = 8'h02;
	localparam logic [7:0] RATE_DIV_1 = 8'h08;
	localparam logic [7:0] RATE_DIV_2 = 8'h20;
	localparam logic [7:0] RATE_DIV_3 = 8'h80;

	// Sixteen clock edges and eight samples make one byte.
	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [2:0] LAST_SAMPLE = 3'h7;

	// Index of each pin in the input synchroniser.
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_MOSI = 1;
	localparam int SYNC_MISO = 2;
	localparam int SYNC_SEL = 3;
	localparam logic [3:0] SYNC_RESET = 4'h8;

	typedef enum logic [0:0] {
		SCS_IDLE = 1'b0,
		SCS_BUSY = 1'b1
	} scs_xfer_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic err_ie;
		logic mode_fault_flag_en;
		logic [1:0] rate;
		logic rx_full;
		logic overrun;
		logic mode_fault;
		logic tx_empty;
		logic ovr_armed;
		logic mode_fault_flag_armed;
		logic [7:0] tx_buf;
		logic [7:0] rx_buf;
		logic [7:0] shifter;
		logic shifter_loaded;
		logic sample_due;
		scs_xfer_t xfer;
		logic [3:0] edge_cnt;
		logic [2:0] sample_cnt;
		logic [7:0] div_cnt;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic sclk_prev;
		logic sel_prev;
		logic sclk_lvl;
		logic data_out;
		logic [7:0] rd_data;
		logic sclk_o;
		logic sclk_oe_n;
		logic mosi_o;
		logic mosi_oe_n;
		logic miso_o;
		logic miso_oe_n;
		logic pullup_en;
		logic irq_rx;
		logic irq_tx;
		logic irq_err;
	} scs_state_t;

	localparam scs_state_t STATE_RESET = '{
		ctl: CONTROL_RESET,
		tx_empty: 1'b1,
		xfer: SCS_IDLE,
		sync1: SYNC_RESET,
		sync2: SYNC_RESET,
		sel_prev: 1'b1,
		sclk_oe_n: 1'b1,
		mosi_oe_n: 1'b1,
		miso_oe_n: 1'b1,
		pullup_en: 1'b1,
		default: '0
	};

endpackage : scs_pkg

/* File: src/scs_port.sv */
// Byte-wide synchronous serial port: registers, controller and target engine.
// Assumes register strobes come from logic on ref_clk and that all serial
// pins arrive asynchronously and are resolved to wire levels outside.

// Overview of operation
// (R1) Polarity bit sets idle clock level.
// (R2) Phase 0: controller raises select between bytes; the port has no select output, select_n is only an input.
// (R3) Phase 0 target: select fall starts, MSB out.
// (R4) No shifter reload once a transfer started.
// (R5) Phase 1 target: first clock edge starts.
// (R6) High select: MISO released, clocks ignored.
// (R7) Wired-OR bit makes pins open-drain, no pullups.
// (R8) Enable bit runs port; clearing partially resets.
// (R9) Transmit-empty interrupt enable gates its request.
// (R10) Receive-full sets on byte; data read clears.
// (R11) Error enable gates mode-fault and overrun requests.
// (R12) Overrun keeps old byte, drops new one.
// (R13) Overrun clears: status read, then data read.
// (R14) Mode fault: target select rise, controller select low.
// (R15) Mode fault clears: status read, then status write.
// (R16) Transmit-empty sets when buffer feeds shifter.
// (R17) Idle port refills shifter within two cycles.
// (R18) Software writes data only when transmit-empty.
// (R19) Target select always input; enable only masks fault.
// (R20) Controller without fault enable ignores select.
// (R21) Rate bits pick divisor 2, 8, 32, 128.
// (R22) Data writes transmit buffer, reads receive buffer.
// (R23) Target only when not controller, select low.
// (R24) Level interrupt outputs follow enabled flags.
module scs_port
	import scs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_n,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_n,
	input wire logic select_n,
	output logic pullup_en,
	output logic irq_rx_full,
	output logic irq_tx_empty,
	output logic irq_error
);
	import scs_pkg::*;

	function automatic logic [7:0] rate_divisor(input logic [1:0] sel);
		logic [7:0] d;
		unique case (sel)
			2'b00: d = RATE_DIV_0;
			2'b01: d = RATE_DIV_1;
			2'b10: d = RATE_DIV_2;
			2'b11: d = RATE_DIV_3;
		endcase
		return d;
	endfunction : rate_divisor

	// A pin driven low only, or both ways; oe_n low means driven.
	function automatic logic pin_oe_n(input logic drive, input logic wom,
		input logic level);
		return !(drive && (!wom || !level));
	endfunction : pin_oe_n

	scs_state_t st;
	scs_state_t next_st;

	logic sclk_s;
	logic mosi_s;
	logic miso_s;
	logic sel_n_s;
	logic en;
	logic master;
	logic clock_polarity_bit;
	logic clock_phase_bit;
	logic wom;
	logic target_sel;
	logic data_wr;
	logic data_rd;
	logic clk_edge;
	logic leading;
	logic sample_edge;
	logic busy_now;
	logic done;
	logic byte_in;
	logic din;
	logic [7:0] divisor;

	always_comb begin
		next_st = st;
		clk_edge = 1'b0;
		leading = 1'b0;
		sample_edge = 1'b0;
		busy_now = 1'b0;
		done = 1'b0;
		byte_in = 1'b0;
		din = 1'b0;

		next_st.sync1 = {select_n, miso_in, mosi_in, serial_clock_pin_in};
		next_st.sync2 = st.sync1;
		sclk_s = st.sync2[SYNC_SCLK];
		mosi_s = st.sync2[SYNC_MOSI];
		miso_s = st.sync2[SYNC_MISO];
		sel_n_s = st.sync2[SYNC_SEL];
		next_st.sclk_prev = sclk_s;
		next_st.sel_prev = sel_n_s;

		en = st.ctl[CTL_EN];
		master = st.ctl[CTL_MASTER];
		clock_polarity_bit = st.ctl[CTL_CLOCK_POLARITY_BIT];
		clock_phase_bit = st.ctl[CTL_CLOCK_PHASE_BIT];
		wom = st.ctl[CTL_WOM];
		din = master ? miso_s : mosi_s;
		target_sel = en && !master && !sel_n_s; // (R23) (R19)
		divisor = rate_divisor(st.rate); // (R21)
		data_wr = wr_en && (addr == ADDR_DATA);
		data_rd = rd_en && (addr == ADDR_DATA);

		// Register port; clears act first so that hardware sets win below, except the transmit-empty set, which yields to a data write.
		next_st.rd_data = 8'h00;
		if (wr_en) begin
			unique case (addr)
				ADDR_CONTROL: begin
					next_st.ctl = wr_data & CONTROL_WR_MASK;
				end
				ADDR_STATUS: begin
					next_st.err_ie = wr_data[ST_ERR_IE];
					next_st.mode_fault_flag_en = wr_data[ST_MODE_FAULT_FLAG_EN];
					next_st.rate = wr_data[ST_RATE_HI:ST_RATE_LO];
					if (st.mode_fault_flag_armed) begin
						next_st.mode_fault = 1'b0; // (R15)
						next_st.mode_fault_flag_armed = 1'b0;
					end
				end
				ADDR_DATA: begin
					next_st.tx_buf = wr_data; // (R22)
					next_st.tx_empty = 1'b0;
				end
				default: begin
				end
			endcase
		end
		if (rd_en) begin
			unique case (addr)
				ADDR_CONTROL: begin
					next_st.rd_data = st.ctl;
				end
				ADDR_STATUS: begin
					next_st.rd_data = {st.rx_full, st.err_ie, st.overrun,
						st.mode_fault, st.tx_empty, st.mode_fault_flag_en, st.rate};
					if (st.overrun) begin
						next_st.ovr_armed = 1'b1; // (R13)
					end
					if (st.mode_fault) begin
						next_st.mode_fault_flag_armed = 1'b1; // (R15)
					end
				end
				ADDR_DATA: begin
					next_st.rd_data = st.rx_buf; // (R22)
					next_st.rx_full = 1'b0; // (R10)
					if (st.ovr_armed) begin
						next_st.overrun = 1'b0; // (R13)
						next_st.ovr_armed = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		if (!en) begin
			// Partial reset: the engine and the shifter are abandoned, the
			// transmit buffer counts as empty, flags and settings stay.
			next_st.xfer = SCS_IDLE; // (R8)
			next_st.shifter_loaded = 1'b0;
			next_st.edge_cnt = 4'h0;
			next_st.sample_cnt = 3'h0;
			next_st.div_cnt = 8'h00;
			next_st.sample_due = 1'b0;
			next_st.sclk_lvl = clock_polarity_bit;
			next_st.tx_empty = 1'b1;
		end else begin
			// An idle, empty shifter takes the buffer on the next edge.
			if (st.xfer == SCS_IDLE && !st.shifter_loaded && !st.tx_empty
					&& !st.sample_due) begin
				next_st.shifter = st.tx_buf; // (R17)
				next_st.shifter_loaded = 1'b1;
				next_st.data_out = st.tx_buf[7];
				if (!data_wr) begin
					next_st.tx_empty = 1'b1; // (R16)
				end
			end

			if (master) begin
				if (st.xfer == SCS_IDLE) begin
					next_st.sclk_lvl = clock_polarity_bit; // (R1)
					if (st.shifter_loaded) begin
						next_st.xfer = SCS_BUSY;
						next_st.div_cnt = 8'h00;
						next_st.edge_cnt = 4'h0;
						next_st.sample_cnt = 3'h0;
						next_st.data_out = st.shifter[7];
					end
				end else if (st.div_cnt == divisor - 8'h01) begin
					next_st.div_cnt = 8'h00;
					clk_edge = 1'b1;
					next_st.sclk_lvl = !st.sclk_lvl;
					next_st.edge_cnt = st.edge_cnt + 4'h1;
					leading = !st.edge_cnt[0];
					if (st.edge_cnt == LAST_EDGE) begin
						done = 1'b1;
					end
				end else begin
					next_st.div_cnt = st.div_cnt + 8'h01; // (R21)
				end
				busy_now = st.xfer == SCS_BUSY;
			end else begin
				// Target: clocks count only while selected.
				leading = sclk_s != st.sclk_prev && sclk_s != clock_polarity_bit; // (R6)
				clk_edge = target_sel && sclk_s != st.sclk_prev; // (R6)
				if (st.xfer == SCS_IDLE && target_sel) begin
					if (!clock_phase_bit && st.sel_prev) begin
						next_st.xfer = SCS_BUSY; // (R3)
						next_st.sample_cnt = 3'h0;
						next_st.data_out = st.shifter[7]; // (R3)
					end else if (clock_phase_bit && clk_edge && leading) begin
						next_st.xfer = SCS_BUSY; // (R5)
						next_st.sample_cnt = 3'h0;
						busy_now = 1'b1;
					end
				end
				if (st.xfer == SCS_BUSY) begin
					busy_now = 1'b1;
				end
				if (st.xfer == SCS_BUSY && st.mode_fault_flag_en && sel_n_s
						&& !st.sel_prev) begin
					next_st.mode_fault = 1'b1; // (R14) (R19)
				end
			end

			sample_edge = leading ^ clock_phase_bit;
			if (busy_now && clk_edge) begin
				if (sample_edge && master) begin
					next_st.sample_due = 1'b1;
				end else if (sample_edge) begin
					next_st.shifter = {st.shifter[6:0], din};
					next_st.sample_cnt = st.sample_cnt + 3'h1;
					if (st.sample_cnt == LAST_SAMPLE) begin
						done = 1'b1;
						byte_in = 1'b1;
					end
				end else begin
					next_st.data_out = st.shifter[7];
				end
			end

			// The synchronised input bit lags the pin by two cycles, so the
			// controller takes it one cycle after its own sampling edge;
			// otherwise the fastest rate would read the previous bit.
			if (st.sample_due) begin
				next_st.sample_due = 1'b0;
				next_st.shifter = {st.shifter[6:0], din};
				next_st.sample_cnt = st.sample_cnt + 3'h1;
				if (st.sample_cnt == LAST_SAMPLE) begin
					byte_in = 1'b1;
				end
			end

			// The shifter is never reloaded while busy; a byte written now
			// waits in the buffer until the transfer ends.
			if (done) begin
				next_st.xfer = SCS_IDLE; // (R4)
				next_st.shifter_loaded = 1'b0; // (R4)
				next_st.sclk_lvl = clock_polarity_bit;
			end
			if (byte_in) begin
				if (next_st.rx_full) begin
					next_st.overrun = 1'b1; // (R12)
				end else begin
					next_st.rx_buf = {st.shifter[6:0], din}; // (R10)
					next_st.rx_full = 1'b1; // (R10)
				end
			end

			// In controller mode select is watched only when fault detection is on.
			if (master && st.mode_fault_flag_en && !sel_n_s) begin
				next_st.mode_fault = 1'b1; // (R14) (R20)
			end
		end

		// Pin drivers; wired-OR drives only lows and turns pullups off.
		next_st.sclk_o = wom ? 1'b0 : next_st.sclk_lvl; // (R7)
		next_st.sclk_oe_n = pin_oe_n(en && master, wom,
			next_st.sclk_lvl); // (R7) (R1)
		next_st.mosi_o = wom ? 1'b0 : next_st.data_out; // (R7)
		next_st.mosi_oe_n = pin_oe_n(en && master, wom,
			next_st.data_out); // (R7)
		next_st.miso_o = wom ? 1'b0 : next_st.data_out; // (R7)
		next_st.miso_oe_n = pin_oe_n(target_sel, wom,
			next_st.data_out); // (R6) (R23)
		next_st.pullup_en = !wom; // (R7)

		next_st.irq_rx = next_st.rx_full && st.ctl[CTL_RX_IE]; // (R24) (R10)
		next_st.irq_tx = next_st.tx_empty && st.ctl[CTL_TX_IE]; // (R9) (R24)
		next_st.irq_err = st.err_ie
			&& (next_st.overrun || next_st.mode_fault); // (R11) (R24)
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign serial_clock_pin_out = st.sclk_o;
	assign serial_clock_pin_oe_n = st.sclk_oe_n;
	assign mosi_out = st.mosi_o;
	assign mosi_oe_n = st.mosi_oe_n;
	assign miso_out = st.miso_o;
	assign miso_oe_n = st.miso_oe_n;
	assign pullup_en = st.pullup_en;
	assign irq_rx_full = st.irq_rx;
	assign irq_tx_empty = st.irq_tx;
	assign irq_error = st.irq_err;

endmodule : scs_port
